// ### shared/dsd_pkg.sv
package dsd_pkg;
    // channel function code, three octal digits
    localparam int FN_W = 9;
    localparam int W = 16;
    // function groups (upper two octal digits of the code)
    localparam logic [5:0] GRP_REL = 6'h00; // 000 release, 001 rel-opp+select
    localparam logic [5:0] GRP_SEL = 6'h01;
    localparam logic [5:0] GRP_RST = 6'h02; // 020 clear faults, 021 reset
    localparam logic [5:0] GRP_GST = 6'h05;
    localparam logic [5:0] GRP_RCS = 6'h06;
    localparam logic [5:0] GRP_DIAG = 6'h07;
    localparam logic [2:0] GRP_RW = 3'h2;   // 2xx read/write family
    localparam logic [8:0] FN_CLR_FLT = 9'h010;
    localparam logic [8:0] FN_RESET = 9'h011;
    // drive-level function codes that the drive treats as invalid
    localparam logic [3:0] DRV_DATA_FN = 4'h6;
    localparam logic [3:0] DRV_UNUSED_FN = 4'hA;
    // diagnostic select parcel codes
    localparam logic [15:0] DG_BIN_PAR = 16'h0001;
    localparam logic [15:0] DG_STAT_PAR = 16'h0002;
    localparam logic [15:0] DG_WE_FLAW = 16'h0004;
    localparam logic [15:0] DG_WE_SCRATCH = 16'h0008;
    localparam logic [15:0] DG_WP_DATA = 16'h0010;
    localparam logic [15:0] DG_UP_REQ = 16'h0801;
    localparam logic [15:0] DG_UP_CONF = 16'h0402;
    localparam logic [15:0] DG_DN_REQ = 16'h0802;
    localparam logic [15:0] DG_DN_CONF = 16'h0404;
    localparam logic [15:0] DG_SERVO = 16'h0803;
    localparam logic [15:0] DG_EDC_1 = 16'h0804;
    localparam logic [15:0] DG_EDC_N = 16'h0805;
    localparam int DGB_BIN_PAR = 0;     // type-B parcel bit positions
    localparam int DGB_STAT_PAR = 1;
    // type-A general status bit positions
    localparam int GA_MAINT = 15;
    localparam int GA_SEQ = 13;
    localparam int GA_INVALID = 12;
    localparam int GA_LOST = 11;
    // type-B general status bit positions
    localparam int GB_CHAN = 6;
    // controller status bit positions
    localparam int CS_BIN_PAR = 0;
    localparam int CS_STAT_PAR = 1;
    localparam int CS_READY = 2;
    localparam int CS_REJECT = 3;
    localparam int CS_OVERRUN = 4;
    localparam logic [15:0] CS_KEEP = 16'h0007;
    localparam logic [15:0] ZERO16 = 16'h0000;
    // synchronised pin vector: 16 drive flags then single pins
    localparam int SY_DONE = 16;
    localparam int SY_TYPEB = 17;
    localparam int SY_READY = 18;
    localparam int SY_PANEL = 19;
    localparam int SY_W = 20;
    // spindle sequence length, in cycles of sys_clk
    localparam logic [15:0] SEQ_CYCLES = 16'h0400;
    typedef enum logic [2:0] {
        DSD_IDLE = 3'b001,
        DSD_WAIT = 3'b010,
        DSD_RESP = 3'b100
    } dsd_state_t;
endpackage

// ### shared/dsd_stat_if.sv
`timescale 1ns/1ps
interface dsd_stat_if;
    logic        type_b;
    logic        maint;
    logic        seq_busy;
    logic        set_invalid;
    logic        set_lost;
    logic        clr_faults;
    logic [15:0] flags;
    logic [15:0] word;
    modport ctl (output type_b, maint, seq_busy, set_invalid, set_lost,
                 clr_faults, flags, input word);
    modport gen (input type_b, maint, seq_busy, set_invalid, set_lost,
                 clr_faults, flags, output word);
endinterface

// ### core/dsd_gsw.sv
`timescale 1ns/1ps
module dsd_gsw (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic clk_en,
    // status sources and assembled word
    dsd_stat_if.gen   st
);
    logic invalid;
    logic lost;
    logic [15:0] next_word;

    ////////////////////////////////////////////////////////////////////
    // sticky drive flags; a new event wins over a clear in one cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            invalid <= 1'b0;
            lost <= 1'b0;
        end else if (clk_en) begin
            if (st.set_invalid) begin
                invalid <= 1'b1;
            end else if (st.clr_faults) begin
                invalid <= 1'b0;
            end
            if (st.set_lost) begin
                lost <= 1'b1;
            end else if (st.clr_faults) begin
                lost <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // word layout depends on which drive type is attached
    always_comb begin
        next_word = st.flags;
        if (st.type_b) begin
            // command errors fold into the bus-out channel error
            next_word[dsd_pkg::GB_CHAN] = st.flags[dsd_pkg::GB_CHAN]
                                        | invalid | lost;
        end else begin
            next_word[dsd_pkg::GA_MAINT] = st.maint;
            next_word[dsd_pkg::GA_SEQ] = st.seq_busy | st.flags[13];
            next_word[dsd_pkg::GA_INVALID] = invalid;
            next_word[dsd_pkg::GA_LOST] = lost;
        end
    end

    // registered so the fetch sees a stable word
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st.word <= dsd_pkg::ZERO16;
        end else if (clk_en) begin
            st.word <= next_word;
        end
    end
endmodule

// ### core/dsd_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - general status fetch loads drive status register
// - type-A bits 15..9 drive condition flags
// - type-A bits 8..5 per-channel read errors
// - type-A bits 4..0 option, seek, data, parity
// - maintenance bit set while any write mode
// - during spindle sequence only few functions succeed
// - data code outside read/write, or unused, invalid
// - unexpected function strobe sets function lost
// - type-B bits 15..12 last-error sector status
// - type-B bits 11..8 fault, seek, cylinder, ready
// - type-B bits 7,6 buffer and channel errors
// - type-B drive number and sector of error
// - controller status read answers two parcels immediately
// - status read clears all but three bits
// - diagnostic select leaves parcel three as status
// - diagnostic codes force bus-in or status parity
// - cylinder write-enable/protect codes set maintenance mode
// - spindle up needs request then confirm
// - spindle down needs request then confirm
// - servo calibration and memory error tests start
// - write modes persist until select/release/reset/diag
// - done pulse ends function, captures bus-in
module dsd_ctrl (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        clk_en,
    // channel function request
    input  wire logic        fn_valid,
    input  wire logic [8:0]  fn_code,
    input  wire logic [15:0] fn_parcel3,
    // channel response
    output logic             resp_valid,
    output logic [15:0]      resp_data,
    output logic             busy,
    // drive pins (asynchronous)
    input  wire logic [15:0] drv_flags,
    input  wire logic        drv_done,
    input  wire logic        drv_type_b,
    input  wire logic        drv_ready,
    input  wire logic        drv_panel_seq,
    // drive commands
    output logic             drv_start,
    output logic [15:0]      drv_bus_out,
    output logic             spindle_up,
    output logic             spindle_down,
    output logic [2:0]       diag_start,
    // cylinder protection state
    output logic             flaw_map_cylinder_we,
    output logic             scratch_diag_cylinder_we,
    output logic             data_cyl_wp,
    // registers
    output logic [15:0]      drive_status,
    output logic [15:0]      ctrl_status
);
    dsd_stat_if st ();
    dsd_pkg::dsd_state_t state;
    logic [dsd_pkg::SY_W-1:0] sync1;
    logic [dsd_pkg::SY_W-1:0] sync2;
    logic [dsd_pkg::SY_W-1:0] pins;
    logic done_d;
    logic done_pulse;
    logic [8:0] cur_fn;
    logic [15:0] cur_p3;
    logic arm_up;
    logic arm_down;
    logic [15:0] seq_cnt;
    logic seq_busy;
    logic accept;
    logic reject;
    logic drive_fn;
    logic cs_clear;
    logic set_bin;
    logic set_stp;

    ////////////////////////////////////////////////////////////////////
    // function decode helpers
    function automatic logic [5:0] grp(input logic [8:0] c);
        grp = c[8:3];
    endfunction

    // functions the drive still honours while spinning up or down
    function automatic logic seq_ok(input logic [8:0] c);
        seq_ok = (grp(c) == dsd_pkg::GRP_REL) || (grp(c) == dsd_pkg::GRP_SEL)
              || (grp(c) == dsd_pkg::GRP_GST) || (grp(c) == dsd_pkg::GRP_RCS);
    endfunction

    // functions that drop write-enable/protect modes
    function automatic logic drops_wmode(input logic [8:0] c);
        drops_wmode = (grp(c) == dsd_pkg::GRP_REL)
                   || (grp(c) == dsd_pkg::GRP_SEL) || (c == dsd_pkg::FN_RESET);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // two-flop synchronisers for every drive pin
    assign pins = {drv_panel_seq, drv_ready, drv_type_b, drv_done, drv_flags};
    genvar g;
    generate
        for (g = 0; g < dsd_pkg::SY_W; g++) begin : g_sync
            always_ff @(posedge sys_clk or negedge nrst) begin
                if (!nrst) begin
                    sync1[g] <= 1'b0;
                    sync2[g] <= 1'b0;
                end else if (clk_en) begin
                    sync1[g] <= pins[g];
                    sync2[g] <= sync1[g];
                end
            end
        end
    endgenerate

    // done edge is taken from the second flop only
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            done_d <= 1'b0;
        end else if (clk_en) begin
            done_d <= sync2[dsd_pkg::SY_DONE];
        end
    end
    assign done_pulse = sync2[dsd_pkg::SY_DONE] && !done_d;

    ////////////////////////////////////////////////////////////////////
    // request classification
    assign accept = fn_valid && state == dsd_pkg::DSD_IDLE;
    assign reject = accept && seq_busy && !seq_ok(fn_code);
    assign drive_fn = accept && !reject && grp(fn_code) != dsd_pkg::GRP_RCS;
    assign cs_clear = state == dsd_pkg::DSD_RESP;
    // parity forcing lands when the diagnostic completes
    assign set_bin = state == dsd_pkg::DSD_WAIT && done_pulse
        && grp(cur_fn) == dsd_pkg::GRP_DIAG
        && (st.type_b ? cur_p3[dsd_pkg::DGB_BIN_PAR]
                      : cur_p3 == dsd_pkg::DG_BIN_PAR);
    assign set_stp = state == dsd_pkg::DSD_WAIT && done_pulse
        && grp(cur_fn) == dsd_pkg::GRP_DIAG
        && (st.type_b ? cur_p3[dsd_pkg::DGB_STAT_PAR]
                      : cur_p3 == dsd_pkg::DG_STAT_PAR);

    // status composer inputs
    assign st.type_b = sync2[dsd_pkg::SY_TYPEB];
    assign st.flags = sync2[15:0];
    assign st.seq_busy = seq_busy;
    assign st.maint = flaw_map_cylinder_we | scratch_diag_cylinder_we
                    | data_cyl_wp;
    // a strobe while a function is outstanding was not expected
    assign st.set_lost = fn_valid && state != dsd_pkg::DSD_IDLE;
    assign st.set_invalid = drive_fn
        && (fn_code[3:0] == dsd_pkg::DRV_UNUSED_FN
            || fn_code[8:6] != dsd_pkg::GRP_RW
               && fn_code[3:0] == dsd_pkg::DRV_DATA_FN);
    assign st.clr_faults = drive_fn && (fn_code == dsd_pkg::FN_CLR_FLT
                                     || fn_code == dsd_pkg::FN_RESET);

    dsd_gsw u_gsw (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .clk_en  (clk_en),
        .st      (st)
    );

    ////////////////////////////////////////////////////////////////////
    // function sequencer
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= dsd_pkg::DSD_IDLE;
            cur_fn <= 9'h000;
            cur_p3 <= 16'h0000;
        end else if (clk_en) begin
            unique case (state)
                dsd_pkg::DSD_IDLE: begin
                    if (accept && !reject) begin
                        cur_fn <= fn_code;
                        cur_p3 <= fn_parcel3;
                        // status read skips the remaining parcels
                        state <= grp(fn_code) == dsd_pkg::GRP_RCS
                               ? dsd_pkg::DSD_RESP
                               : dsd_pkg::DSD_WAIT;
                    end
                end
                dsd_pkg::DSD_WAIT: begin
                    if (done_pulse) begin
                        state <= dsd_pkg::DSD_IDLE;
                    end
                end
                dsd_pkg::DSD_RESP: begin
                    state <= dsd_pkg::DSD_IDLE;
                end
                default: begin
                    state <= dsd_pkg::DSD_IDLE;
                end
            endcase
        end
    end

    // channel answers and drive start strobe
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            resp_valid <= 1'b0;
            resp_data <= 16'h0000;
            busy <= 1'b0;
            drv_start <= 1'b0;
            drv_bus_out <= 16'h0000;
        end else if (clk_en) begin
            resp_valid <= 1'b0;
            drv_start <= drive_fn;
            if (drive_fn) begin
                drv_bus_out <= fn_parcel3;
            end
            if (accept && !reject && grp(fn_code) == dsd_pkg::GRP_RCS) begin
                resp_valid <= 1'b1;
                resp_data <= drive_status;
            end else if (state == dsd_pkg::DSD_RESP) begin
                resp_valid <= 1'b1;
                resp_data <= ctrl_status;
            end
            busy <= accept && !reject || state == dsd_pkg::DSD_WAIT
                    && !done_pulse;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // drive status register: left alone by the status read
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            drive_status <= 16'h0000;
        end else if (clk_en) begin
            if (state == dsd_pkg::DSD_WAIT && done_pulse) begin
                // diagnostics echo parcel three, others the drive word
                drive_status <= grp(cur_fn) == dsd_pkg::GRP_DIAG
                              ? cur_p3 : st.word;
            end
        end
    end

    // controller status; events win over the read-clear
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_status <= 16'h0000;
        end else if (clk_en) begin
            if (cs_clear) begin
                ctrl_status <= ctrl_status & dsd_pkg::CS_KEEP;
            end
            if (drive_fn && fn_code == dsd_pkg::FN_CLR_FLT) begin
                ctrl_status <= 16'h0000;
            end
            ctrl_status[dsd_pkg::CS_READY] <= sync2[dsd_pkg::SY_READY];
            if (set_bin) begin
                ctrl_status[dsd_pkg::CS_BIN_PAR] <= 1'b1;
            end
            if (set_stp) begin
                ctrl_status[dsd_pkg::CS_STAT_PAR] <= 1'b1;
            end
            if (reject) begin
                ctrl_status[dsd_pkg::CS_REJECT] <= 1'b1;
            end
            if (st.set_lost) begin
                ctrl_status[dsd_pkg::CS_OVERRUN] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // cylinder protection modes held until a cancelling function
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            flaw_map_cylinder_we <= 1'b0;
            scratch_diag_cylinder_we <= 1'b0;
            data_cyl_wp <= 1'b0;
        end else if (clk_en) begin
            if (drive_fn && grp(fn_code) == dsd_pkg::GRP_DIAG) begin
                flaw_map_cylinder_we <= fn_parcel3 == dsd_pkg::DG_WE_FLAW;
                scratch_diag_cylinder_we
                    <= fn_parcel3 == dsd_pkg::DG_WE_SCRATCH;
                data_cyl_wp <= fn_parcel3 == dsd_pkg::DG_WP_DATA;
            end else if (drive_fn && drops_wmode(fn_code)) begin
                flaw_map_cylinder_we <= 1'b0;
                scratch_diag_cylinder_we <= 1'b0;
                data_cyl_wp <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // spindle request/confirm pairs; any other diagnostic disarms
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            arm_up <= 1'b0;
            arm_down <= 1'b0;
            spindle_up <= 1'b0;
            spindle_down <= 1'b0;
            diag_start <= 3'h0;
        end else if (clk_en) begin
            spindle_up <= 1'b0;
            spindle_down <= 1'b0;
            diag_start <= 3'h0;
            if (drive_fn && grp(fn_code) == dsd_pkg::GRP_DIAG) begin
                arm_up <= fn_parcel3 == dsd_pkg::DG_UP_REQ;
                arm_down <= fn_parcel3 == dsd_pkg::DG_DN_REQ;
                spindle_up <= arm_up && fn_parcel3 == dsd_pkg::DG_UP_CONF;
                spindle_down <= arm_down
                             && fn_parcel3 == dsd_pkg::DG_DN_CONF;
                diag_start <= {fn_parcel3 == dsd_pkg::DG_EDC_N,
                               fn_parcel3 == dsd_pkg::DG_EDC_1,
                               fn_parcel3 == dsd_pkg::DG_SERVO};
            end
        end
    end

    // sequence-in-progress timer; the panel switch also counts
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            seq_cnt <= 16'h0000;
        end else if (clk_en) begin
            if (spindle_up || spindle_down) begin
                seq_cnt <= dsd_pkg::SEQ_CYCLES;
            end else if (seq_cnt != 16'h0000) begin
                seq_cnt <= seq_cnt - 16'h0001;
            end
        end
    end
    assign seq_busy = seq_cnt != 16'h0000 || sync2[dsd_pkg::SY_PANEL];
endmodule

// ### verif/dsd_ctrl_props.sv
`timescale 1ns/1ps
module dsd_ctrl_props (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // channel
    input  wire logic        fn_valid,
    input  wire logic [8:0]  fn_code,
    input  wire logic [15:0] fn_parcel3,
    input  wire logic        resp_valid,
    input  wire logic [15:0] resp_data,
    input  wire logic        busy,
    // drive
    input  wire logic [15:0] drv_flags,
    input  wire logic        drv_done,
    input  wire logic        drv_type_b,
    input  wire logic        drv_start,
    input  wire logic [15:0] drv_bus_out,
    input  wire logic        spindle_up,
    input  wire logic        spindle_down,
    input  wire logic [2:0]  diag_start,
    // modes and registers
    input  wire logic        flaw_map_cylinder_we,
    input  wire logic        scratch_diag_cylinder_we,
    input  wire logic        data_cyl_wp,
    input  wire logic [15:0] drive_status,
    input  wire logic [15:0] ctrl_status
);
    logic        take;
    logic [5:0]  last_grp;
    logic [15:0] last_dg;
    logic [15:0] prev_dg;
    logic [2:0]  modes;
    assign take = fn_valid && !busy && !resp_valid;
    assign modes = {flaw_map_cylinder_we, scratch_diag_cylinder_we,
                    data_cyl_wp};
    // last accepted group and last two diag parcels, for arming checks
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            last_grp <= 6'h00;
            last_dg <= 16'h0000;
            prev_dg <= 16'h0000;
        end else if (take) begin
            last_grp <= fn_code[8:3];
            if (fn_code[8:3] == dsd_pkg::GRP_DIAG) begin
                prev_dg <= last_dg;
                last_dg <= fn_parcel3;
            end
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence rcs_take_s;
        take && fn_code[8:3] == dsd_pkg::GRP_RCS;
    endsequence
    sequence rcs_pair_s;
        resp_valid && resp_data == $past(drive_status)
        ##1 resp_valid && resp_data == $past(ctrl_status);
    endsequence
    chk_rcs_pair: assert property (rcs_take_s |=> rcs_pair_s)
        else $error("status read parcels wrong");
    chk_rcs_clear: assert property (
        rcs_take_s |-> ##3 (ctrl_status & ~dsd_pkg::CS_KEEP) == 16'h0000
            && drive_status == $past(drive_status, 3))
        else $error("status read clear wrong");
    chk_gst_issue: assert property (
        take && fn_code[8:3] == dsd_pkg::GRP_GST |=> busy && drv_start
            && drv_bus_out == $past(fn_parcel3))
        else $error("status fetch not issued");
    chk_done_ends: assert property (
        busy && $rose(drv_done) |-> ##[1:4] !busy)
        else $error("done did not end function");
    chk_gst_word: assert property (
        $fell(busy) && last_grp == dsd_pkg::GRP_GST |-> (drv_type_b ?
        {drive_status[15:7], drive_status[5:0]} ==
        {drv_flags[15:7], drv_flags[5:0]} :
        {drive_status[14], drive_status[10:0]} ==
        {drv_flags[14], drv_flags[10:0]}))
        else $error("general status word wrong");
    chk_maint_bit: assert property (
        $fell(busy) && last_grp == dsd_pkg::GRP_GST && !drv_type_b
            |-> drive_status[dsd_pkg::GA_MAINT] == (modes != 3'h0))
        else $error("maintenance bit wrong");
    chk_diag_parcel: assert property (
        $fell(busy) && last_grp == dsd_pkg::GRP_DIAG
            |-> drive_status == last_dg)
        else $error("diag parcel not in status");
    chk_mode_decode: assert property (
        take && fn_code[8:3] == dsd_pkg::GRP_DIAG |-> ##2 modes ==
        {last_dg == dsd_pkg::DG_WE_FLAW, last_dg == dsd_pkg::DG_WE_SCRATCH,
         last_dg == dsd_pkg::DG_WP_DATA})
        else $error("write mode decode wrong");
    chk_spindle_armed: assert property (
        spindle_up || spindle_down |-> spindle_up
            ? (prev_dg == dsd_pkg::DG_UP_REQ && last_dg == dsd_pkg::DG_UP_CONF)
            : (prev_dg == dsd_pkg::DG_DN_REQ && last_dg == dsd_pkg::DG_DN_CONF))
        else $error("spindle command not armed");
    chk_diag_start: assert property (
        diag_start != 3'h0 |-> diag_start == {last_dg == dsd_pkg::DG_EDC_N,
        last_dg == dsd_pkg::DG_EDC_1, last_dg == dsd_pkg::DG_SERVO})
        else $error("diag start wrong");
endmodule
bind dsd_ctrl dsd_ctrl_props u_dsd_ctrl_props (.*);

// ### verif/dsd_drive_model.sv
`timescale 1ns/1ps
module dsd_drive_model (
    // clock
    input  wire logic       sys_clk,
    // command and answer
    input  wire logic       drv_start,
    input  wire logic [3:0] delay,
    output logic            drv_done
);
    // each command answered after a chosen delay; done held two cycles
    // drive side keeps pace with the controller, so no data flags rise
    initial drv_done = 1'h0;
    always begin
        @(posedge sys_clk);
        #1;
        if (drv_start === 1'h1) begin
            repeat (delay) @(posedge sys_clk);
            #1 drv_done = 1'h1;
            repeat (2) @(posedge sys_clk);
            #1 drv_done = 1'h0;
        end
    end
endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        sys_clk, nrst, fn_valid, resp_valid, busy, drv_done;
    logic        drv_type_b, drv_ready, drv_start, spindle_up, spindle_down;
    logic        flaw_map_cylinder_we, scratch_diag_cylinder_we, data_cyl_wp;
    logic [8:0]  fn_code;
    logic [15:0] fn_parcel3, resp_data, drv_flags, drv_bus_out;
    logic [15:0] drive_status, ctrl_status;
    logic [3:0]  delay;
    logic [2:0]  diag_start, ds_seen;
    int          error_cnt, tests_run, up_cnt, dn_cnt, st_cnt;
    logic [15:0] modes;
    dsd_ctrl u_dsd_ctrl (.*, .clk_en(1'h1), .drv_panel_seq(1'h0));
    assign modes = {13'h0, flaw_map_cylinder_we, scratch_diag_cylinder_we,
                    data_cyl_wp};
    dsd_drive_model u_dsd_drive_model (.sys_clk, .drv_start, .delay,
        .drv_done);
    always #5 sys_clk = ~sys_clk;
    // tallies of one-cycle command pulses
    always @(posedge sys_clk) begin
        if (spindle_up === 1'h1) up_cnt++;
        if (spindle_down === 1'h1) dn_cnt++;
        if (drv_start === 1'h1) st_cnt++;
        if (diag_start !== 3'h0) ds_seen = ds_seen | diag_start;
    end
    ////////////////////////////////////////
    // all stimulus moves 1 ns after the edge, clear of sampling
    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("mismatches %0d comparisons %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // strobe one function (twice if dup, to hit a busy controller)
    task automatic run_fn(input logic [8:0] c, input logic [15:0] p,
                          input bit dup = 1'h0);
        fn_valid = 1'h1;
        fn_code = c;
        fn_parcel3 = p;
        tick();
        if (dup) tick();
        fn_valid = 1'h0;
        for (int n = 0; busy !== 1'h0; n++) begin
            if (n > 300) begin
                error_cnt++;
                test_done();
            end
            tick();
        end
        tick();
    endtask
    task automatic gst_check(input logic [15:0] exp);
        run_fn(9'h028, 16'h0000);
        check16(drive_status, exp);
    endtask
    task automatic set_drive(input logic tb, input logic [15:0] f);
        drv_type_b = tb;
        drv_flags = f;
        repeat (4) tick();
    endtask
    ////////////////////////////////////////
    task automatic t_gst;
        set_drive(1'h0, 16'h47A5);
        gst_check(16'h47A5);
        set_drive(1'h1, 16'hA5B5);
        gst_check(16'hA5B5);
        set_drive(1'h0, 16'h0000);
    endtask
    task automatic t_invalid;
        logic [8:0] bad [2] = '{9'h00A, 9'h016};
        for (int i = 0; i < 2; i++) begin
            run_fn(bad[i], 16'h0000);
            gst_check(16'h1000);
            run_fn(dsd_pkg::FN_CLR_FLT, 16'h0000);
        end
    endtask
    task automatic t_parity;
        for (int i = 1; i < 4; i++) begin
            set_drive(i == 3, 16'h0000);
            run_fn(dsd_pkg::FN_CLR_FLT, 16'h0000);
            run_fn(9'h038, 16'(i));
            check16(drive_status, 16'(i));
            check16(ctrl_status, 16'h0004 | 16'(i));
        end
        set_drive(1'h0, 16'h0000);
    endtask
    task automatic t_modes;
        logic [15:0] md [3] = '{dsd_pkg::DG_WE_FLAW, dsd_pkg::DG_WE_SCRATCH,
                                dsd_pkg::DG_WP_DATA};
        logic [8:0] clr [4] = '{9'h000, 9'h008, dsd_pkg::FN_RESET, 9'h038};
        for (int i = 0; i < 4; i++) begin
            run_fn(9'h038, md[i % 3]);
            check16(modes, 16'h0004 >> (i % 3));
            gst_check(16'h8000);
            run_fn(clr[i], 16'h0000);
            check16(modes, 16'h0000);
        end
    endtask
    task automatic t_spindle;
        int s;
        run_fn(dsd_pkg::FN_CLR_FLT, 16'h0000);
        run_fn(9'h038, dsd_pkg::DG_UP_CONF);
        check16(16'(up_cnt), 16'h0000);
        run_fn(9'h038, dsd_pkg::DG_UP_REQ);
        run_fn(9'h038, dsd_pkg::DG_UP_CONF);
        check16(16'(up_cnt), 16'h0001);
        gst_check(16'h2000);
        s = st_cnt;
        run_fn(9'h038, dsd_pkg::DG_SERVO);
        check16(16'(st_cnt - s), 16'h0000);
        check16(ctrl_status, 16'h000C);
        repeat (1100) tick();
        run_fn(9'h038, dsd_pkg::DG_DN_REQ);
        run_fn(9'h038, dsd_pkg::DG_DN_CONF);
        check16(16'(dn_cnt), 16'h0001);
        repeat (1100) tick();
        for (int i = 0; i < 3; i++) begin
            ds_seen = 3'h0;
            run_fn(9'h038, dsd_pkg::DG_SERVO + 16'(i));
            check16(16'(ds_seen), 16'h0001 << i);
        end
    endtask
    task automatic t_lost;
        run_fn(dsd_pkg::FN_CLR_FLT, 16'h0000);
        delay = 4'hC;
        run_fn(9'h028, 16'h0000, 1'h1);
        gst_check(16'h0800);
        fn_valid = 1'h1;
        fn_code = 9'h030;
        tick();
        fn_valid = 1'h0;
        check16(16'(resp_valid), 16'h0001);
        check16(resp_data, 16'h0800);
        tick();
        check16(16'(resp_valid), 16'h0001);
        check16(resp_data, 16'h0014);
        tick();
        check16(ctrl_status, 16'h0004);
        check16(drive_status, 16'h0800);
    endtask
    ////////////////////////////////////////
    initial begin
        {sys_clk, nrst, fn_valid, fn_code, fn_parcel3} = '0;
        {drv_flags, drv_type_b, ds_seen} = '0;
        {error_cnt, tests_run, up_cnt, dn_cnt, st_cnt} = '0;
        drv_ready = 1'h1;
        delay = 4'h1;
        repeat (6) @(posedge sys_clk);
        #1 nrst = 1'h1;
        tick();
        t_gst();
        t_invalid();
        t_parity();
        t_modes();
        t_spindle();
        t_lost();
        test_done();
    end
endmodule
